// ===== rtl/drc_ctrl.sv
// Purpose: host controller driving a 256K x 1 dynamic ram through its strobe pins
// Assumes: one request at a time; timing counts from the fastest speed grade
// Notes:   refresh uses column-before-row cycles; a page keeps the row open
`timescale 1ns/1ps
`default_nettype none
module drc_ctrl #(
	parameter int REFI_CYC  = drc_pkg::T_REFI,
	parameter int PWRUP_CYC = drc_pkg::T_PWRUP,
	parameter int RASMX_CYC = drc_pkg::T_RAS_MAX
) (
	// clock and reset
	input  wire logic                       CLK,
	input  wire logic                       RESET,
	// user request
	input  wire logic                       REQ_VALID,
	input  wire logic                       REQ_WRITE,
	input  wire logic [drc_pkg::ADDR_W-1:0] REQ_ADDR,
	input  wire logic                       REQ_WDATA,
	input  wire logic                       REQ_PAGE,
	output logic                            REQ_READY,
	output logic                            RSP_VALID,
	output logic                            RSP_RDATA,
	output logic                            INIT_DONE,
	// dram pins
	output logic [drc_pkg::MUX_W-1:0]       MUXED_ADDR,
	output logic                            ROW_STROBE_N,
	output logic                            COL_STROBE_N,
	output logic                            WRITE_STROBE_N,
	output logic                            DATA_IN,
	input  wire logic                       DATA_OUT
);
	typedef enum logic [3:0] {
		S_BOOT, S_PWRUP, S_IDLE, S_ROW, S_COL, S_COLW, S_PAGE, S_PRE,
		S_CBR_SET, S_CBR_HOLD, S_CBR_RAS
	} drc_state_e;

	// local copies of the package widths so size casts stay plain
	localparam int CNT_W  = drc_pkg::CNT_W;
	localparam int INIT_W = drc_pkg::INIT_W;

	drc_state_e                   st_q, st_d;
	logic [drc_pkg::MUX_W-1:0]    addr_q, addr_d;
	logic                         ras_q, ras_d, cas_q, cas_d, we_q, we_d, din_q, din_d;
	logic                         rdy_q, rdy_d, rv_q, rv_d, rd_q, rd_d, init_q, init_d;
	logic                         wr_q, wr_d;
	logic [drc_pkg::INIT_W-1:0]   icnt_q, icnt_d;
	logic [drc_pkg::CNT_W-1:0]    refc_q, refc_d;
	logic                         rfpend_q, rfpend_d;
	logic [drc_pkg::CNT_W-1:0]    rasc_q, rasc_d;
	logic [drc_pkg::CNT_W-1:0]    rcc_q, rcc_d;
	logic                         tload;
	logic [drc_pkg::CNT_W-1:0]    tval;
	logic                         tdone;

	// one interval timer serves every strobe phase
	drc_timer u_timer (
		.clk   (CLK),
		.reset (RESET),
		.load  (tload),
		.value (tval),
		.done  (tdone)
	);

	// main sequencer: one strobe phase per state, every phase ended by the timer
	always_comb begin
		st_d     = st_q;
		addr_d   = addr_q;
		ras_d    = ras_q;
		cas_d    = cas_q;
		we_d     = we_q;
		din_d    = din_q;
		rdy_d    = 1'b0;
		rv_d     = 1'b0;
		rd_d     = rd_q;
		init_d   = init_q;
		wr_d     = wr_q;
		icnt_d   = icnt_q;
		tload    = 1'b0;
		tval     = '0;
		// refresh tick: one row due every REFI_CYC+1 cycles, so at the default 256 rows take 1000192 cycles, just over 4 ms
		refc_d   = (refc_q == '0) ? CNT_W'(REFI_CYC) : refc_q - drc_pkg::CNT_ONE;
		rfpend_d = rfpend_q | (refc_q == '0);
		// row-open time, checked against the maximum pulse width
		rasc_d   = ras_q ? '0 : rasc_q + drc_pkg::CNT_ONE;
		rcc_d    = (rcc_q == '0) ? '0 : rcc_q - drc_pkg::CNT_ONE;
		case (st_q)
			S_BOOT: begin
				// the timer comes out of reset at zero, so the pause is loaded here
				tload = 1'b1;
				tval  = CNT_W'(PWRUP_CYC);
				st_d  = S_PWRUP;
			end
			S_PWRUP: begin
				if (tdone) begin
					st_d   = S_CBR_SET;
					cas_d  = 1'b0;
					tload  = 1'b1;
					tval   = CNT_W'(drc_pkg::T_CSR);
				end
			end
			S_IDLE: begin
				// start-up refreshes run back to back; a tick in this cycle stays pending
				if ((rfpend_q || !init_q) && rcc_q == '0) begin
					rfpend_d = (refc_q == '0);
					st_d     = S_CBR_SET;
					cas_d    = 1'b0;
					tload    = 1'b1;
					tval     = CNT_W'(drc_pkg::T_CSR);
				end else if (REQ_VALID && init_q && rcc_q == '0) begin
					rdy_d  = 1'b1;
					addr_d = REQ_ADDR[drc_pkg::ADDR_W-1:drc_pkg::MUX_W];
					rcc_d  = CNT_W'(drc_pkg::T_RC);
					st_d   = S_ROW;
					ras_d  = 1'b0;
					wr_d   = REQ_WRITE;
					din_d  = REQ_WDATA;
					we_d   = ~REQ_WRITE;
					tload  = 1'b1;
					tval   = CNT_W'(drc_pkg::T_RCD);
					rd_d   = REQ_ADDR[0];
				end
			end
			S_ROW: begin
				// column taken once, one cycle after accept, so the caller may move on
				if (rdy_q) begin
					addr_d = REQ_ADDR[drc_pkg::MUX_W-1:0];
				end
				if (tdone) begin
					cas_d = 1'b0;
					st_d  = S_COL;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_RAC - drc_pkg::T_RCD);
				end
			end
			S_COL: begin
				if (tdone) begin
					if (!wr_q) begin
						rv_d = 1'b1;
						rd_d = DATA_OUT;
					end
					// column released so the device floats its output
					cas_d = 1'b1;
					we_d  = 1'b1;
					st_d  = S_COLW;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_CP);
				end
			end
			S_COLW: begin
				if (tdone) begin
					// a hit is taken only while two whole page cycles remain before the row-open limit
					if (REQ_VALID && REQ_PAGE && !rfpend_q &&
					    (rasc_q < CNT_W'(RASMX_CYC - drc_pkg::T_PC - drc_pkg::T_PC))) begin
						// page hit: new column while the row stays open
						rdy_d  = 1'b1;
						wr_d   = REQ_WRITE;
						din_d  = REQ_WDATA;
						we_d   = ~REQ_WRITE;
						addr_d = REQ_ADDR[drc_pkg::MUX_W-1:0];
						st_d   = S_PAGE;
						tload  = 1'b1;
						tval   = CNT_W'(drc_pkg::T_PC - drc_pkg::T_CAS - drc_pkg::T_CP);
					end else begin
						ras_d = 1'b1;
						st_d  = S_PRE;
						tload = 1'b1;
						tval  = CNT_W'(drc_pkg::T_RP);
					end
				end
			end
			S_PAGE: begin
				if (tdone) begin
					cas_d = 1'b0;
					st_d  = S_COL;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_CAS);
				end
			end
			S_PRE: begin
				if (tdone) begin
					st_d = S_IDLE;
				end
			end
			S_CBR_SET: begin
				if (tdone) begin
					ras_d = 1'b0;
					st_d  = S_CBR_HOLD;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_CHR);
				end
			end
			S_CBR_HOLD: begin
				if (tdone) begin
					cas_d = 1'b1;
					st_d  = S_CBR_RAS;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_RAS - drc_pkg::T_CHR);
				end
			end
			S_CBR_RAS: begin
				if (tdone) begin
					ras_d = 1'b1;
					rcc_d = CNT_W'(drc_pkg::T_RC);
					st_d  = S_PRE;
					tload = 1'b1;
					tval  = CNT_W'(drc_pkg::T_RP);
					// count the eight start-up refresh cycles; device steps its own row counter
					if (!init_q) begin
						icnt_d = icnt_q + 1'b1;
						init_d = (icnt_q == INIT_W'(drc_pkg::INIT_CYCLES - 1));
					end
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	// register every state and pin so outputs come straight from flops
	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_q     <= S_BOOT;
			addr_q   <= '0;
			ras_q    <= 1'b1;
			cas_q    <= 1'b1;
			we_q     <= 1'b1;
			din_q    <= 1'b0;
			rdy_q    <= 1'b0;
			rv_q     <= 1'b0;
			rd_q     <= 1'b0;
			init_q   <= 1'b0;
			wr_q     <= 1'b0;
			icnt_q   <= '0;
			refc_q   <= '0;
			rfpend_q <= 1'b0;
			rasc_q   <= '0;
			rcc_q    <= '0;
		end else begin
			st_q     <= st_d;
			addr_q   <= addr_d;
			ras_q    <= ras_d;
			cas_q    <= cas_d;
			we_q     <= we_d;
			din_q    <= din_d;
			rdy_q    <= rdy_d;
			rv_q     <= rv_d;
			rd_q     <= rd_d;
			init_q   <= init_d;
			wr_q     <= wr_d;
			icnt_q   <= icnt_d;
			refc_q   <= refc_d;
			rfpend_q <= rfpend_d;
			rasc_q   <= rasc_d;
			rcc_q    <= rcc_d;
		end
	end

	// pin and status outputs
	assign MUXED_ADDR     = addr_q;
	assign ROW_STROBE_N   = ras_q;
	assign COL_STROBE_N   = cas_q;
	assign WRITE_STROBE_N = we_q;
	assign DATA_IN        = din_q;
	assign REQ_READY      = rdy_q;
	assign RSP_VALID      = rv_q;
	assign RSP_RDATA      = rd_q;
	assign INIT_DONE      = init_q;
endmodule : drc_ctrl
`default_nettype wire

// ===== rtl/drc_pkg.sv
// Purpose: constants for the 256K x 1 dram controller (host end of the strobe interface)
// Assumes: 250 MHz clock, fastest speed grade timing used as defaults
// Notes:   times are kept in ns (or us) as printed, cycle counts are derived from them
package drc_pkg;
	localparam int CLK_PERIOD_NS      = 4;
	localparam int ADDR_W             = 18;
	localparam int MUX_W              = 9;
	// speed-grade times in ns, refresh window and power-up pause in us, plus row and cycle counts
	localparam int RANDOM_CYCLE_MIN_NS = 190;
	localparam int ROW_TO_COL_DELAY_NS = 25;
	localparam int ROW_TO_COL_MAX_NS   = 50;
	localparam int CBR_COL_SETUP_NS    = 10;
	localparam int CBR_COL_HOLD_NS     = 30;
	localparam int PAGE_CYCLE_MIN_NS   = 100;
	localparam int ROW_ACCESS_TIME_NS  = 100;
	localparam int ROW_PULSE_MIN_NS    = 100;
	localparam int ROW_PULSE_MAX_NS    = 10000;
	localparam int ROW_PRECHARGE_NS    = 80;
	localparam int COL_PULSE_MIN_NS    = 50;
	localparam int COL_PRECHARGE_NS    = 40;
	localparam int REFRESH_PERIOD_US   = 4000;
	localparam int REFRESH_ROWS        = 256;
	localparam int POWERUP_PAUSE_US    = 200;
	localparam int INIT_CYCLES         = 8;
	// least times round up, longest round down
	localparam int T_RCD     = (ROW_TO_COL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RCD_MAX = ROW_TO_COL_MAX_NS / CLK_PERIOD_NS;
	localparam int T_CSR     = (CBR_COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_CHR     = (CBR_COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RAC     = (ROW_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RAS     = (ROW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RAS_MAX = ROW_PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int T_RP      = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_CAS     = (COL_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_CP      = (COL_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RC      = (RANDOM_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PC      = (PAGE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// refresh interval per row, rounded down; with the controller's extra reload cycle 256 rows run just past the window
	localparam int T_REFI    = (REFRESH_PERIOD_US * 1000 / REFRESH_ROWS) / CLK_PERIOD_NS;
	localparam int T_PWRUP   = (POWERUP_PAUSE_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W     = 16;
	localparam int INIT_W    = 4;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : drc_pkg

// ===== rtl/drc_timer.sv
// Purpose: down counter timing strobe intervals for the dram controller
// Assumes: load takes priority over counting
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module drc_timer (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// control
	input  wire logic                      load,
	input  wire logic [drc_pkg::CNT_W-1:0] value,
	// status
	output logic                           done
);
	logic [drc_pkg::CNT_W-1:0] cnt_q;
	logic [drc_pkg::CNT_W-1:0] cnt_d;

	// next count: reload or step toward zero
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = value;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - drc_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == '0);
endmodule : drc_timer
`default_nettype wire

// ===== testbench/drc_ctrl_properties.sv
// Purpose: checks on the dram pins driven by the controller
// Assumes: one clock domain, synchronous active high reset
// Notes:   fall and refresh counters saturate, row-low counter clears while the row is closed, so long idle spans cannot wrap
`timescale 1ns/1ps
`default_nettype none
module drc_ctrl_chk #(
	parameter int RASMX_CYC = drc_pkg::T_RAS_MAX
) (
	// clock and reset
	input wire logic                       CLK,
	input wire logic                       RESET,
	// user side
	input wire logic                       RSP_VALID,
	input wire logic                       INIT_DONE,
	input wire logic [drc_pkg::ADDR_W-1:0] REQ_ADDR,
	// dram pins
	input wire logic [drc_pkg::MUX_W-1:0]  MUXED_ADDR,
	input wire logic                       ROW_STROBE_N,
	input wire logic                       COL_STROBE_N,
	input wire logic                       WRITE_STROBE_N
);
	logic [15:0] fall_q, fall_d, low_q, low_d;
	logic [3:0]  cbr_q, cbr_d;
	logic        rowp_q, colp_q, row_fell, cbr_go;
	// edges seen against the previous sample
	assign row_fell = rowp_q & ~ROW_STROBE_N;
	assign cbr_go = colp_q & ~COL_STROBE_N & ROW_STROBE_N;
	// interval counters; saturation keeps long idle spans from wrapping
	always_comb begin
		fall_d = row_fell ? 16'h0001 : fall_q + {15'h0000, fall_q != 16'hFFFF};
		low_d = ROW_STROBE_N ? 16'h0000 : low_q + 16'h0001;
		cbr_d = cbr_q + {3'h0, cbr_go && cbr_q != 4'hF};
	end
	always_ff @(posedge CLK) begin
		if (RESET) begin
			fall_q <= 16'hFFFF;
			low_q <= 16'h0000;
			cbr_q <= 4'h0;
			rowp_q <= 1'b1;
			colp_q <= 1'b1;
		end else begin
			fall_q <= fall_d;
			low_q <= low_d;
			cbr_q <= cbr_d;
			rowp_q <= ROW_STROBE_N;
			colp_q <= COL_STROBE_N;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_rc; row_fell |-> fall_q >= 16'(drc_pkg::T_RC); endproperty
	a_rc: assert property (p_rc) else $error("row strobes too close");
	property p_rcd; $fell(COL_STROBE_N) && !ROW_STROBE_N |-> low_q >= 16'(drc_pkg::T_RCD); endproperty
	a_rcd: assert property (p_rcd) else $error("column strobe too soon");
	property p_csr; row_fell && !COL_STROBE_N |->
		($past(COL_STROBE_N, 1) | $past(COL_STROBE_N, 2) | $past(COL_STROBE_N, 3)) == 1'b0; endproperty
	a_csr: assert property (p_csr) else $error("refresh column setup short");
	property p_chr; row_fell && !COL_STROBE_N |-> !COL_STROBE_N [*8]; endproperty
	a_chr: assert property (p_chr) else $error("refresh column hold short");
	property p_rasmx; !ROW_STROBE_N |-> low_q < 16'(RASMX_CYC); endproperty
	a_rasmx: assert property (p_rasmx) else $error("row strobe held too long");
	property p_init; $rose(INIT_DONE) |-> cbr_q >= 4'h8; endproperty
	a_init: assert property (p_init) else $error("ready before eight refreshes");
	property p_radr; row_fell && COL_STROBE_N |-> MUXED_ADDR == REQ_ADDR[17:9]; endproperty
	a_radr: assert property (p_radr) else $error("row address wrong");
	property p_ewr; $fell(COL_STROBE_N) && !WRITE_STROBE_N |-> !$past(WRITE_STROBE_N); endproperty
	a_ewr: assert property (p_ewr) else $error("write strobe not early");
	property p_rsp; $fell(COL_STROBE_N) && !ROW_STROBE_N && WRITE_STROBE_N |-> ##[1:40] RSP_VALID;
	endproperty
	a_rsp: assert property (p_rsp) else $error("read answer missing");
endmodule : drc_ctrl_chk
bind drc_ctrl drc_ctrl_chk #(.RASMX_CYC(RASMX_CYC)) u_drc_ctrl_chk (.CLK(CLK), .RESET(RESET),
	.RSP_VALID(RSP_VALID), .INIT_DONE(INIT_DONE), .REQ_ADDR(REQ_ADDR), .MUXED_ADDR(MUXED_ADDR),
	.ROW_STROBE_N(ROW_STROBE_N), .COL_STROBE_N(COL_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N));
`default_nettype wire

// ===== testbench/drc_dram_model.sv
// Purpose: behavioural 256K x 1 dynamic ram on the controller's pins
// Assumes: access times of the fastest grade, answered at the latest
// Notes:   unwritten cells read as zero
`timescale 1ns/1ps
`default_nettype none
module drc_dram_model #(
	parameter int RAC_NS = 100,
	parameter int CAC_NS = 50
) (
	// pins from the controller
	input wire logic [drc_pkg::MUX_W-1:0] muxed_addr,
	input wire logic                      row_strobe_n,
	input wire logic                      col_strobe_n,
	input wire logic                      write_strobe_n,
	input wire logic                      data_in,
	// read data
	output logic                          data_out
);
	bit                        mem [0:262143];
	logic [drc_pkg::MUX_W-1:0] row, col, rctr;
	logic                      last;
	realtime                   t_row;
	// nothing pulls the output, so a released pin shows the inverse of its last value
	initial begin
		rctr = 9'h000;
		last = 1'b0;
		data_out = 1'b1;
	end
	// row latch, or refresh of the internal counter row when the column is low first
	always @(negedge row_strobe_n) begin
		t_row = $realtime;
		if (col_strobe_n) row = muxed_addr;
		else rctr = rctr + 9'h001;
	end
	// column latch in an open row: early write stores, a read answers at the latest
	always @(negedge col_strobe_n) if (!row_strobe_n) begin
		col = muxed_addr;
		if (!write_strobe_n) mem[{row, col}] = data_in;
		else begin
			#(CAC_NS);
			if ($realtime < t_row + RAC_NS) #(t_row + RAC_NS - $realtime);
			if (!col_strobe_n) begin
				data_out = mem[{row, col}];
				last = data_out;
			end
		end
	end
	// late write strobe latches the data instead
	always @(negedge write_strobe_n) if (!row_strobe_n && !col_strobe_n) mem[{row, col}] = data_in;
	// output released when the column strobe rises
	always @(posedge col_strobe_n) data_out = ~last;
endmodule : drc_dram_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the dram controller with a ram model
// Assumes: shortened power-up, refresh and row-open counts
// Notes:   reads compare against values written earlier in the run, or zero for cells never written
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {logic w; logic [17:0] a; logic d; logic p;} drc_op_s;
	logic clk, reset, req_valid, req_write, req_wdata, req_page;
	logic [drc_pkg::ADDR_W-1:0] req_addr;
	logic req_ready, rsp_valid, rsp_rdata, init_done, row_n, col_n, we_n, din, dout;
	logic [drc_pkg::MUX_W-1:0] maddr, r0;
	int n_fail = 0;
	int cmp_count = 0;
	// write, address, data or expected bit, page
	drc_op_s rows [10] = '{'{1'b1, 18'h00000, 1'b1, 1'b0}, '{1'b1, 18'h001FF, 1'b1, 1'b1},
		'{1'b0, 18'h00000, 1'b1, 1'b1}, '{1'b0, 18'h001FF, 1'b1, 1'b1},
		'{1'b0, 18'h00200, 1'b0, 1'b0}, '{1'b0, 18'h00201, 1'b0, 1'b1},
		'{1'b1, 18'h3FFFF, 1'b1, 1'b0}, '{1'b1, 18'h3FE00, 1'b0, 1'b1},
		'{1'b0, 18'h3FFFF, 1'b1, 1'b0}, '{1'b0, 18'h3FE00, 1'b0, 1'b1}};
	drc_ctrl #(.REFI_CYC(200), .PWRUP_CYC(20), .RASMX_CYC(100)) u_drc_ctrl (.CLK(clk), .RESET(reset),
		.REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
		.REQ_PAGE(req_page), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
		.INIT_DONE(init_done), .MUXED_ADDR(maddr), .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n),
		.WRITE_STROBE_N(we_n), .DATA_IN(din), .DATA_OUT(dout));
	drc_dram_model u_drc_dram_model (.muxed_addr(maddr), .row_strobe_n(row_n),
		.col_strobe_n(col_n), .write_strobe_n(we_n), .data_in(din), .data_out(dout));
	task automatic chk(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %b wanted %b", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// one request held until taken; a read then waits for its answer
	task automatic do_op(input drc_op_s op);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= op.w;
		req_addr <= op.a;
		req_wdata <= op.d;
		req_page <= op.p;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 1500);
		chk(req_ready, 1'b1);
		req_valid <= 1'b0;
		if (!op.w) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (rsp_valid !== 1'b1 && n < 100);
			chk(rsp_valid, 1'b1);
			chk(rsp_rdata, op.d);
		end
	endtask : do_op
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// main sequence; the first request waits out start-up without being taken
	initial begin
		{reset, req_valid, req_write, req_wdata, req_page} = 5'h10;
		req_addr = 18'h00000;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) do_op(rows[i]);
		chk(u_drc_dram_model.rctr >= 9'h008, 1'b1);
		// idle span long enough for several refresh intervals
		r0 = u_drc_dram_model.rctr;
		repeat (700) @(posedge clk);
		chk(9'(u_drc_dram_model.rctr - r0) >= 9'h003, 1'b1);
		// reset in mid-write: pins go quiet, start-up repeats, stored data survives
		do_op('{1'b1, 18'h12345, 1'b1, 1'b0});
		repeat (12) @(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		chk(row_n & col_n & we_n, 1'b1);
		chk(init_done, 1'b0);
		reset <= 1'b0;
		do_op('{1'b0, 18'h3FFFF, 1'b1, 1'b0});
		do_op('{1'b0, 18'h12345, 1'b1, 1'b0});
		wrap_up;
	end
	// watchdog set well past the few thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up;
	end
endmodule : tb_top
`default_nettype wire
